// ==== nvc_consts.svh ====
/*
 * nvc_consts.svh: offsets, field positions, reset values and timing counts
 * for the byte-wide nonvolatile data store controller.
 * assumes: included by bare name; clock 10 MHz, calibrated oscillator tick.
 */
`ifndef NVC_CONSTS_SVH
`define NVC_CONSTS_SVH

// ----------------------------------------
// register offsets in i/o space
// ----------------------------------------
`define NVC_OFF_INDEX      6'h1e
`define NVC_OFF_VALUE      6'h1d
`define NVC_OFF_CONTROL    6'h1c

// ----------------------------------------
// control field positions
// ----------------------------------------
`define NVC_BIT_READ       0
`define NVC_BIT_GO         1
`define NVC_BIT_ARM        2
`define NVC_BIT_RDY_IE     3
`define NVC_BIT_MODE_LO    4
`define NVC_BIT_MODE_HI    5

// ----------------------------------------
// reset values
// ----------------------------------------
`define NVC_RST_MODE       2'h0
`define NVC_RST_BYTE       8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define NVC_ARM_CYCLES     3'h4
`define NVC_READ_STALL     3'h4
`define NVC_PROG_STALL     3'h2
// oscillator tick period in ns and programming times in us
`define NVC_OSC_TICK_NS    1000
`define NVC_T_ATOMIC_US    3400
`define NVC_T_SPLIT_US     1800
`define NVC_T_ATOMIC_TICKS (`NVC_T_ATOMIC_US * 1000 / `NVC_OSC_TICK_NS)
`define NVC_T_SPLIT_TICKS  (`NVC_T_SPLIT_US * 1000 / `NVC_OSC_TICK_NS)

`endif

// ==== nvc_pkg.sv ====
/*
 * nvc_pkg: types shared by both ends of the controller.
 * assumes: nothing beyond the consts header.
 */
package nvc_pkg;

	typedef enum logic [1:0] {
		nvc_mode_atomic = 2'h0,
		nvc_mode_erase  = 2'h1,
		nvc_mode_write  = 2'h2,
		nvc_mode_resv   = 2'h3
	} nvc_mode_t;

	typedef enum logic [2:0] {
		nvc_st_idle  = 3'h1,
		nvc_st_prog  = 3'h2,
		nvc_st_stall = 3'h4
	} nvc_state_t;

endpackage : nvc_pkg

// ==== nvc_bus_if.sv ====
/*
 * nvc_bus_if: i/o space port between the processor core and the controller.
 * assumes: one clock; core writes or reads one register per cycle.
 */
`timescale 1ns/1ps
interface nvc_bus_if;
	logic       io_wr;
	logic       io_rd;
	logic [5:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	logic       cpu_stall;
	logic       ready_irq;

	modport dev (
		input  io_wr, io_rd, io_addr, io_wdata,
		output io_rdata, cpu_stall, ready_irq
	);
	modport core (
		output io_wr, io_rd, io_addr, io_wdata,
		input  io_rdata, cpu_stall, ready_irq
	);
endinterface : nvc_bus_if

// ==== nvc_ctrl.sv ====
/*
 * nvc_ctrl: 128-byte data store with index, value and control registers,
 * read strobe, armed programming in three modes, ready interrupt, cpu stall.
 * assumes: core holds io requests while cpu_stall is high; osc_tick is a
 * one-cycle pulse from the calibrated oscillator divider, same clock.
 */
// Operation
// - read stalls processor four cycles
// - go stalls processor two cycles
// - index is 7 bits, bit 7 reads zero
// - value feeds programming, receives read data
// - control bits 7..6 read zero
// - mode selects atomic, erase, write, reserved
// - mode writes ignored while go set
// - reset clears mode unless programming
// - ready interrupt while enabled and idle
// - arm self-clears after four cycles
// - go starts only within arm window
// - go stays set until time elapses
// - read completes within one instruction
// - no read or index change while programming
// - no other operation while busy
// - write-only needs prior erase
// - programming timed by calibrated oscillator
// - software arms then sets go
// - software polls go before reading
// - software writes index before access
// - reset lets running programming finish
`timescale 1ns/1ps
`include "nvc_consts.svh"
module nvc_ctrl
	import nvc_pkg::*;
#(
	parameter int ATOMIC_TICKS = `NVC_T_ATOMIC_TICKS,
	parameter int SPLIT_TICKS  = `NVC_T_SPLIT_TICKS
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// oscillator timebase
	input  wire logic osc_tick,
	// core side
	nvc_bus_if.dev    bus,
	// status
	input  wire logic global_irq_enable,
	output logic      prog_busy
);

	typedef struct packed {
		logic [6:0]  index;
		logic [7:0]  value;
		nvc_mode_t   mode;
		logic        rdy_ie;
		logic        arm;
		logic [2:0]  arm_cnt;
		logic        go;
		nvc_state_t  st;
		logic [2:0]  stall_cnt;
		logic [11:0] ticks;
		nvc_mode_t   op;
		logic [7:0]  rdata;
		logic        stall;
		logic        irq;
	} nvc_ctrl_state_t;

	nvc_ctrl_state_t r;
	nvc_ctrl_state_t next_r;
	logic [7:0]      mem [0:127];
	logic            mem_we;
	logic [7:0]      mem_wd;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic [11:0] op_ticks(input nvc_mode_t m);
		op_ticks = (m == nvc_mode_atomic) ? 12'(ATOMIC_TICKS) : 12'(SPLIT_TICKS);
	endfunction : op_ticks

	logic wr_idx;
	logic wr_val;
	logic wr_ctl;
	assign wr_idx = bus.io_wr && hit(bus.io_addr, `NVC_OFF_INDEX);
	assign wr_val = bus.io_wr && hit(bus.io_addr, `NVC_OFF_VALUE);
	assign wr_ctl = bus.io_wr && hit(bus.io_addr, `NVC_OFF_CONTROL);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		mem_we = 1'b0;
		mem_wd = r.value;
		if (r.arm) begin
			if (r.arm_cnt == 3'h1) begin
				next_r.arm = 1'b0;
			end
			next_r.arm_cnt = r.arm_cnt - 3'h1;
		end
		if (wr_idx && !r.go) begin
			next_r.index = bus.io_wdata[6:0];
		end
		if (wr_val) begin
			next_r.value = bus.io_wdata;
		end
		if (wr_ctl) begin
			next_r.rdy_ie = bus.io_wdata[`NVC_BIT_RDY_IE];
			if (!r.go) begin
				next_r.mode = nvc_mode_t'(bus.io_wdata[`NVC_BIT_MODE_HI:`NVC_BIT_MODE_LO]);
			end
			if (bus.io_wdata[`NVC_BIT_ARM]) begin
				next_r.arm     = 1'b1;
				next_r.arm_cnt = `NVC_ARM_CYCLES;
			end
		end
		case (r.st)
			nvc_st_idle: begin
				// go honoured only inside arm window
				if (wr_ctl && bus.io_wdata[`NVC_BIT_GO] && r.arm) begin
					next_r.go        = 1'b1;
					next_r.op        = r.mode;
					next_r.ticks     = op_ticks(r.mode);
					next_r.arm       = 1'b0;
					next_r.st        = nvc_st_prog;
					next_r.stall     = 1'b1;
					next_r.stall_cnt = `NVC_PROG_STALL;
				end else if (wr_ctl && bus.io_wdata[`NVC_BIT_READ]) begin
					next_r.value     = mem[r.index];
					next_r.stall     = 1'b1;
					next_r.stall_cnt = `NVC_READ_STALL;
					next_r.st        = nvc_st_stall;
				end
			end
			nvc_st_stall: begin
				if (r.stall_cnt == 3'h1) begin
					next_r.stall = 1'b0;
					next_r.st    = nvc_st_idle;
				end
				next_r.stall_cnt = r.stall_cnt - 3'h1;
			end
			nvc_st_prog: begin
				// reads and go ignored while busy
				if (r.stall) begin
					if (r.stall_cnt == 3'h1) begin
						next_r.stall = 1'b0;
					end
					next_r.stall_cnt = r.stall_cnt - 3'h1;
				end
				if (osc_tick) begin
					next_r.ticks = r.ticks - 12'h001;
				end
				if (osc_tick && r.ticks <= 12'h001) begin
					next_r.go = 1'b0;
					next_r.st = nvc_st_idle;
					mem_we = (r.op != nvc_mode_resv);
					case (r.op)
						nvc_mode_atomic: mem_wd = r.value;
						nvc_mode_erase:  mem_wd = 8'hff;
						nvc_mode_write:  mem_wd = mem[r.index] & r.value;
						default:         mem_wd = mem[r.index];
					endcase
				end
			end
			default: begin
				next_r.st = nvc_st_idle;
			end
		endcase
		next_r.irq = r.rdy_ie && global_irq_enable && !next_r.go;
		case (bus.io_addr)
			`NVC_OFF_INDEX:   next_r.rdata = {1'b0, next_r.index};
			`NVC_OFF_VALUE:   next_r.rdata = next_r.value;
			`NVC_OFF_CONTROL: next_r.rdata = {2'h0, next_r.mode, next_r.rdy_ie, next_r.arm, next_r.go, 1'b0};
			default:          next_r.rdata = 8'h00;
		endcase
		if (rst) begin
			next_r.rdy_ie    = 1'b0;
			next_r.arm       = 1'b0;
			next_r.arm_cnt   = 3'h0;
			next_r.stall     = 1'b0;
			next_r.stall_cnt = 3'h0;
			next_r.irq       = 1'b0;
			next_r.rdata     = `NVC_RST_BYTE;
			next_r.value     = `NVC_RST_BYTE;
			// running programming survives reset
			// unknown go at power-up falls into the clearing branch
			if (r.go) begin
				next_r.value = r.value;
			end else begin
				next_r.mode  = nvc_mode_t'(`NVC_RST_MODE);
				next_r.op    = nvc_mode_t'(`NVC_RST_MODE);
				next_r.go    = 1'b0;
				next_r.st    = nvc_st_idle;
				next_r.ticks = 12'h000;
				mem_we       = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		r <= next_r;
		if (mem_we) begin
			mem[r.index] <= mem_wd;
		end
	end

	assign bus.io_rdata  = r.rdata;
	assign bus.cpu_stall = r.stall;
	assign bus.ready_irq = r.irq;
	assign prog_busy     = r.go;

endmodule : nvc_ctrl

// ==== nvc_core.sv ====
/*
 * nvc_core: simple core-side end; turns read/program commands into the
 * documented register sequence and returns read data.
 * assumes: controller on the other side of nvc_bus_if, same clock.
 */
`timescale 1ns/1ps
`include "nvc_consts.svh"
module nvc_core
	import nvc_pkg::*;
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// user commands
	input  wire logic       cmd_valid,
	input  wire logic       cmd_prog,
	input  wire logic [1:0] cmd_mode,
	input  wire logic [6:0] cmd_index,
	input  wire logic [7:0] cmd_value,
	output logic            cmd_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_value,
	// controller side
	nvc_bus_if.core         bus
);

	typedef enum logic [7:0] {
		cs_idle = 8'h01, cs_poll = 8'h02, cs_pwait = 8'h04, cs_index = 8'h08,
		cs_value = 8'h10, cs_arm = 8'h20, cs_kick = 8'h40, cs_fetch = 8'h80
	} nvc_core_state_t;

	typedef struct packed {
		nvc_core_state_t st;
		logic            prog;
		logic [1:0]      mode;
		logic [6:0]      index;
		logic [7:0]      value;
		logic            wr;
		logic            rd;
		logic [5:0]      addr;
		logic [7:0]      wdata;
		logic            ready;
		logic            rvalid;
		logic [7:0]      rval;
	} nvc_core_reg_t;

	nvc_core_reg_t r;
	nvc_core_reg_t next_r;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		next_r        = r;
		next_r.wr     = 1'b0;
		next_r.rd     = 1'b0;
		next_r.rvalid = 1'b0;
		if (!bus.cpu_stall) begin
			case (r.st)
				cs_idle: begin
					if (cmd_valid && r.ready) begin
						next_r.prog  = cmd_prog;
						next_r.mode  = cmd_mode;
						next_r.index = cmd_index;
						next_r.value = cmd_value;
						next_r.ready = 1'b0;
						next_r.st    = cs_poll;
					end
				end
				cs_poll: begin
					next_r.rd   = 1'b1;
					next_r.addr = `NVC_OFF_CONTROL;
					next_r.st   = cs_pwait;
				end
				cs_pwait: begin
					if (!r.rd) begin
						next_r.st = bus.io_rdata[`NVC_BIT_GO] ? cs_poll : cs_index;
					end
				end
				cs_index: begin
					next_r.wr    = 1'b1;
					next_r.addr  = `NVC_OFF_INDEX;
					next_r.wdata = {1'b0, r.index};
					next_r.st    = r.prog ? cs_value : cs_fetch;
				end
				cs_value: begin
					next_r.wr    = 1'b1;
					next_r.addr  = `NVC_OFF_VALUE;
					next_r.wdata = r.value;
					next_r.st    = cs_arm;
				end
				cs_arm: begin
					next_r.wr    = 1'b1;
					next_r.addr  = `NVC_OFF_CONTROL;
					next_r.wdata = {2'h0, r.mode, 1'b0, 1'b1, 2'h0};
					next_r.st    = cs_kick;
				end
				cs_kick: begin
					next_r.wr    = 1'b1;
					next_r.wdata = {2'h0, r.mode, 1'b0, 1'b0, 1'b1, 1'b0};
					next_r.ready = 1'b1;
					next_r.st    = cs_idle;
				end
				cs_fetch: begin
					if (r.addr != `NVC_OFF_CONTROL) begin
						next_r.wr    = 1'b1;
						next_r.addr  = `NVC_OFF_CONTROL;
						next_r.wdata = {2'h0, r.mode, 4'h1};
					end else if (!r.wr) begin
						// strobe taken; stall has passed before the value read
						next_r.rd   = 1'b1;
						next_r.addr = `NVC_OFF_VALUE;
						next_r.st   = cs_idle;
						next_r.rvalid = 1'b0;
					end
				end
				default: begin
					next_r.st = cs_idle;
				end
			endcase
		end
		// value read data stands the cycle after the request
		if (r.st == cs_idle && !r.ready && !r.rd && r.addr == `NVC_OFF_VALUE) begin
			next_r.rvalid = 1'b1;
			next_r.rval   = bus.io_rdata;
			next_r.ready  = 1'b1;
		end
		if (rst) begin
			next_r       = '0;
			next_r.st    = cs_idle;
			next_r.ready = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		r <= next_r;
	end

	assign bus.io_wr    = r.wr;
	assign bus.io_rd    = r.rd;
	assign bus.io_addr  = r.addr;
	assign bus.io_wdata = r.wdata;
	assign cmd_ready    = r.ready;
	assign rsp_valid    = r.rvalid;
	assign rsp_value    = r.rval;

endmodule : nvc_core

// ==== nvc_assertions.sv ====
/*
 * nvc_assertions: timing and field checks on the core-to-controller port.
 * assumes: instantiated beside the interface; one clock, sync reset.
 */
`timescale 1ns/1ps
module nvc_assertions #(
	parameter int ATOMIC_TICKS = 3400,
	parameter int SPLIT_TICKS  = 1800
) (
	// clock, reset and controller status
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       osc_tick,
	input  wire logic       global_irq_enable,
	input  wire logic       prog_busy,
	// register port
	input  wire logic       io_wr,
	input  wire logic       io_rd,
	input  wire logic [5:0] io_addr,
	input  wire logic [7:0] io_wdata,
	input  wire logic [7:0] io_rdata,
	input  wire logic       cpu_stall,
	input  wire logic       ready_irq
);
	logic       wr_ctl;
	logic [2:0] arm_cnt;
	logic [1:0] mode;
	int         ticks;
	int         lim;

	assign wr_ctl = io_wr && io_addr == 6'h1c;
	assign lim    = (mode == 2'h0) ? ATOMIC_TICKS : SPLIT_TICKS;

	// ----------------------------------------
	// arm window, mode and tick models
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (rst)
			arm_cnt <= 3'h0;
		else if (wr_ctl && io_wdata[2] && !prog_busy)
			arm_cnt <= 3'h4;
		else if (arm_cnt != 3'h0)
			arm_cnt <= arm_cnt - 3'h1;
		if (!prog_busy && (rst || wr_ctl))
			mode <= rst ? 2'h0 : io_wdata[5:4];
		ticks <= prog_busy ? ticks + int'(osc_tick) : 0;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	read_stall_a: assert property (
		wr_ctl && io_wdata[1:0] == 2'h1 && !prog_busy |=> cpu_stall [*4] ##1 !cpu_stall
	) else $error("read stall length wrong");
	prog_stall_a: assert property (
		$rose(prog_busy) |-> cpu_stall ##1 cpu_stall ##1 !cpu_stall
	) else $error("program stall length wrong");
	go_refused_a: assert property (
		wr_ctl && io_wdata[1] && !prog_busy && arm_cnt == 3'h0 |=> !prog_busy
	) else $error("go accepted without arm");
	go_taken_a: assert property (
		wr_ctl && io_wdata[1] && !prog_busy && arm_cnt != 3'h0 |=> prog_busy
	) else $error("armed go not accepted");
	busy_hold_a: assert property (
		prog_busy && ticks + 2 < lim |=> prog_busy
	) else $error("programming ended early");
	busy_len_a: assert property (
		$fell(prog_busy) |-> ticks + 1 >= lim && ticks <= lim + 1
	) else $error("programming tick count wrong");
	irq_quiet_a: assert property (
		(prog_busy && $past(prog_busy)) || !(global_irq_enable || $past(global_irq_enable)) |-> !ready_irq
	) else $error("ready interrupt while not allowed");
	ctl_rsvd_a: assert property (
		io_rd && io_addr == 6'h1c |=> io_rdata[7:6] == 2'h0
	) else $error("control reserved bits set");
	idx_rsvd_a: assert property (
		io_addr == 6'h1e |=> !io_rdata[7]
	) else $error("index bit 7 set");
endmodule : nvc_assertions

// ==== nvc_tb_top.sv ====
/*
 * nvc_tb_top: core-driven run and raw register run of the controller.
 * assumes: documented counts on the core port, short ones on the raw port;
 * oscillator tick every fourth clock.
 */
`timescale 1ns/1ps
module nvc_tb_top;
	logic       clock     = 1'b0;
	logic       rst       = 1'b1;
	logic       rst2      = 1'b1;
	logic       osc_tick  = 1'b0;
	logic       tick_en   = 1'b1;
	logic [1:0] tick_div  = 2'h0;
	logic       gie       = 1'b1;
	logic       cmd_valid = 1'b0;
	logic       cmd_prog  = 1'b0;
	logic [1:0] cmd_mode  = 2'h0;
	logic [7:0] cmd_value = 8'h00;
	logic       busy1;
	logic       busy2;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_value;
	logic [7:0] rd;
	logic [7:0] vals [4] = '{8'h5a, 8'h00, 8'h33, 8'h00};
	logic [7:0] exps [4] = '{8'h5a, 8'hff, 8'h33, 8'h33};
	int         n_errors  = 0;
	int         n_tests   = 0;

	nvc_bus_if bus1 ();
	nvc_bus_if bus2 ();

	always #50 clock = ~clock;
	always @(posedge clock) begin
		tick_div <= tick_div + 2'h1;
		osc_tick <= tick_en && tick_div == 2'h3;
	end

	nvc_ctrl nvc_ctrl_i (.clock(clock), .rst(rst), .osc_tick(osc_tick),
		.bus(bus1), .global_irq_enable(gie), .prog_busy(busy1));
	nvc_core nvc_core_i (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_prog(cmd_prog),
		.cmd_mode(cmd_mode), .cmd_index(7'h7f), .cmd_value(cmd_value), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_value(rsp_value), .bus(bus1));
	nvc_ctrl #(.ATOMIC_TICKS(8), .SPLIT_TICKS(4)) nvc_ctrl_i2 (.clock(clock), .rst(rst2), .osc_tick(osc_tick),
		.bus(bus2), .global_irq_enable(gie), .prog_busy(busy2));
	nvc_assertions nvc_assertions_i (.clock(clock), .rst(rst),
		.osc_tick(osc_tick), .global_irq_enable(gie), .prog_busy(busy1), .io_wr(bus1.io_wr),
		.io_rd(bus1.io_rd), .io_addr(bus1.io_addr), .io_wdata(bus1.io_wdata), .io_rdata(bus1.io_rdata),
		.cpu_stall(bus1.cpu_stall), .ready_irq(bus1.ready_irq));

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task end_of_test();
		$display("errors %0d of %0d checks", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	task give_up();
		n_errors++;
		$display("CHECK FAILED at %0t: wait timed out", $time);
		end_of_test();
	endtask : give_up

	// ----------------------------------------
	// raw register access on the second port
	// ----------------------------------------
	task rw(input logic [5:0] a, input logic [7:0] d);
		int i;
		@(negedge clock);
		bus2.io_wr    = 1'b1;
		bus2.io_addr  = a;
		bus2.io_wdata = d;
		@(negedge clock);
		bus2.io_wr    = 1'b0;
		for (i = 0; i < 20 && bus2.cpu_stall !== 1'b0; i++)
			@(negedge clock);
		if (i == 20)
			give_up();
	endtask : rw

	task rchk(input logic [5:0] a, input logic [7:0] exp);
		@(negedge clock);
		bus2.io_rd   = 1'b1;
		bus2.io_addr = a;
		@(negedge clock);
		bus2.io_rd   = 1'b0;
		chk(bus2.io_rdata, exp);
	endtask : rchk

	task wait_idle();
		int i;
		for (i = 0; i < 2000 && busy2 !== 1'b0; i++)
			@(negedge clock);
		if (i == 2000)
			give_up();
	endtask : wait_idle

	task pulse_rst2();
		@(negedge clock);
		rst2 = 1'b1;
		repeat (2) @(negedge clock);
		rst2 = 1'b0;
	endtask : pulse_rst2

	// ----------------------------------------
	// core user side
	// ----------------------------------------
	task core_cmd(input logic p, input logic [1:0] m, input logic [7:0] v, output logic [7:0] r);
		int i;
		@(negedge clock);
		for (i = 0; i < 20000 && cmd_ready !== 1'b1; i++)
			@(negedge clock);
		if (i == 20000)
			give_up();
		cmd_prog  = p;
		cmd_mode  = m;
		cmd_value = v;
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		for (i = 0; !p && i < 20000 && rsp_valid !== 1'b1; i++)
			@(negedge clock);
		if (i == 20000)
			give_up();
		r = rsp_value;
	endtask : core_cmd

	initial begin
		bus2.io_wr    = 1'b0;
		bus2.io_rd    = 1'b0;
		bus2.io_addr  = 6'h00;
		bus2.io_wdata = 8'h00;
		repeat (20) @(negedge clock);
		rst  = 1'b0;
		rst2 = 1'b0;
		// every mode through the core, then read back
		for (int k = 0; k < 4; k++) begin
			core_cmd(1'b1, k[1:0], vals[k], rd);
			core_cmd(1'b0, 2'h0, 8'h00, rd);
			chk(rd, exps[k]);
		end
		rw(6'h1e, 8'hff);
		rchk(6'h1e, 8'h7f);
		rw(6'h1c, 8'hc8);
		rchk(6'h1c, 8'h08);
		chk({7'h00, bus2.ready_irq}, 8'h01);
		gie = 1'b0;
		@(negedge clock);
		chk({7'h00, bus2.ready_irq}, 8'h00);
		gie = 1'b1;
		rw(6'h1c, 8'h00);
		rchk(6'h1c, 8'h00);
		chk({7'h00, bus2.ready_irq}, 8'h00);
		rw(6'h1c, 8'h02);
		rchk(6'h1c, 8'h00);
		rw(6'h1c, 8'h04);
		rchk(6'h1c, 8'h04);
		repeat (4) @(negedge clock);
		rchk(6'h1c, 8'h00);
		rw(6'h1c, 8'h10);
		pulse_rst2();
		rchk(6'h1c, 8'h00);
		// atomic programming with refusals while busy
		rw(6'h1e, 8'h05);
		rw(6'h1d, 8'h3c);
		rw(6'h1c, 8'h04);
		rw(6'h1c, 8'h02);
		rchk(6'h1c, 8'h02);
		rw(6'h1e, 8'h09);
		rchk(6'h1e, 8'h05);
		rw(6'h1c, 8'h32);
		rchk(6'h1c, 8'h02);
		tick_en = 1'b0;
		repeat (100) @(negedge clock);
		chk({7'h00, busy2}, 8'h01);
		tick_en = 1'b1;
		wait_idle();
		rw(6'h1d, 8'h00);
		rw(6'h1c, 8'h01);
		rchk(6'h1d, 8'h3c);
		// erase survives a reset in mid-run
		rw(6'h1c, 8'h14);
		rw(6'h1c, 8'h12);
		pulse_rst2();
		rchk(6'h1c, 8'h12);
		wait_idle();
		rw(6'h1c, 8'h01);
		rchk(6'h1d, 8'hff);
		end_of_test();
	end
endmodule : nvc_tb_top
